/* common/i2c_master_pkg.sv */
// constants, types and register map of the i2c master sequencer
// assumes a 125 MHz system clock and an open-drain i2c bus outside
package i2c_master_pkg;

   // timing: one quarter of a 100 kHz bit time
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned QUARTER_NS    = 2500;
   localparam int unsigned QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_W         = 16;

   // register byte offsets
   localparam int unsigned ADDR_W     = 4;
   localparam logic [3:0]  CTRL_OFS   = 4'h0;
   localparam logic [3:0]  TXDATA_OFS = 4'h4;
   localparam logic [3:0]  RXDATA_OFS = 4'h8;
   localparam logic [3:0]  STATUS_OFS = 4'hC;

   // control register fields
   localparam int unsigned START_BIT    = 0;
   localparam int unsigned RSTART_BIT   = 1;
   localparam int unsigned STOP_BIT     = 2;
   localparam int unsigned RECV_BIT     = 3;
   localparam int unsigned ACKSEQ_BIT   = 4;
   localparam int unsigned ACKVAL_BIT   = 5;
   localparam int unsigned ACK_RECEIVED_STATUS_BIT  = 6;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [7:0]  REQ_MASK     = 8'h1F;

   // status register fields
   localparam int unsigned TX_BUSY_BIT  = 0;
   localparam int unsigned RX_VALID_BIT = 1;
   localparam int unsigned BUSY_BIT     = 2;
   localparam int unsigned RX_FULL_BIT  = 3;

   localparam int unsigned BYTE_W       = 8;
   localparam int unsigned FIFO_DEPTH   = 8;
   localparam logic [3:0]  LAST_TX_BIT  = 4'h8;
   localparam logic [3:0]  LAST_RX_BIT  = 4'h7;

   typedef enum logic [4:0]
   {
      S_IDLE   = 5'h01,
      S_START  = 5'h02,
      S_RSTART = 5'h04,
      S_STOP   = 5'h08,
      S_BITS   = 5'h10
   } engine_state_t;

   typedef enum logic [1:0]
   {
      M_TX  = 2'h0,
      M_RX  = 2'h1,
      M_ACK = 2'h2
   } xfer_mode_t;

   // open-drain drive: oe high pulls the line low
   typedef struct packed
   {
      logic scl_out;
      logic scl_oe;
      logic sda_out;
      logic sda_oe;
   } pin_drive_t;

   typedef struct packed
   {
      logic          scl_in;
      logic          sda_in;
   } pin_sense_t;

   typedef struct packed
   {
      logic [7:0]       ctrl;
      logic             tx_pending;
      engine_state_t    state;
      xfer_mode_t       mode;
      logic [1:0]       step;
      logic [3:0]       bit_cnt;
      logic [7:0]       shift;
      logic [DIV_W-1:0] div_cnt;
      pin_drive_t       pins;
      logic             scl_meta;
      logic             scl_s;
      logic             sda_meta;
      logic             sda_s;
      logic             push;
      logic             wait_q;
      logic [31:0]      rdata;
   } engine_t;

endpackage : i2c_master_pkg

/* src/byte_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock; full refuses a push, empty refuses a pop
`timescale 1ns/1ps
module byte_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
)
(
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wr_ptr;
      logic [PTR_W-1:0]            rd_ptr;
      logic [PTR_W:0]              count;
   } fifo_t;

   fifo_t f_q;
   fifo_t f_d;
   logic  push;
   logic  pop;

   if (DEPTH < 2 || WIDTH < 1)
   begin : g_check
      $error("byte_fifo needs DEPTH of at least 2");
   end

   assign in_ready  = (f_q.count != (PTR_W + 1)'(DEPTH));
   assign out_valid = (f_q.count != '0);
   assign out_data  = f_q.mem[f_q.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      f_d = f_q;
      if (push)
      begin
         f_d.mem[f_q.wr_ptr] = in_data;
         f_d.wr_ptr = (f_q.wr_ptr == LAST_PTR) ? '0 : f_q.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         f_d.rd_ptr = (f_q.rd_ptr == LAST_PTR) ? '0 : f_q.rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
         f_d.count = f_q.count + 1'b1;
      end
      else if (pop && !push)
      begin
         f_d.count = f_q.count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         f_q <= '0;
      end
      else
      begin
         f_q <= f_d;
      end
   end

endmodule : byte_fifo

/* src/i2c_master_sequencer.sv */
// i2c master bus-event sequencer with avalon-mm register slave
// assumes external pull-ups on both lines; pin inputs are asynchronous
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - ack value one sends nack, zero ack
// - ack request runs ack bit, then self-clears
// - receive request clocks in one byte
// - stop request makes stop, then self-clears
// - repeated-start request makes restart, then self-clears
// - start request makes start, then self-clears
// - ack status is set by a slave nack after sent byte
module i2c_master_sequencer
   import i2c_master_pkg::*;
#(
   parameter int unsigned DIV = QUARTER_CYC
)
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output      logic [31:0]       avs_readdata,
   output      logic              avs_waitrequest,
   input  wire pin_sense_t        pin_in,
   output      pin_drive_t        pin_out
);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
   localparam engine_t ST_RESET = '{
      ctrl     : CTRL_RESET,
      state    : S_IDLE,
      mode     : M_TX,
      scl_meta : 1'b1,
      scl_s    : 1'b1,
      sda_meta : 1'b1,
      sda_s    : 1'b1,
      wait_q   : 1'b1,
      default  : '0
   };

   engine_t          st_q;
   engine_t          st_d;
   logic             rx_ready;
   logic             rx_valid;
   logic [BYTE_W-1:0] rx_byte;
   logic             rx_pop;
   logic             fire;
   logic             adv;
   logic [7:0]       clr;

   if (DIV < 2 || DIV > 65535)
   begin : g_check
      $error("DIV must lie between 2 and 65535");
   end

   assign fire   = (avs_read || avs_write) && !st_q.wait_q;
   assign rx_pop = fire && avs_read && (avs_address == RXDATA_OFS);

   byte_fifo
   #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   )
   u_rx_fifo
   (
      .clock     (clock),
      .rst_b     (rst_b),
      .in_valid  (st_q.push),
      .in_ready  (rx_ready),
      .in_data   (st_q.shift),
      .out_valid (rx_valid),
      .out_ready (rx_pop),
      .out_data  (rx_byte)
   );

   always_comb
   begin
      st_d      = st_q;
      st_d.push = 1'b0;
      clr       = 8'h00;
      adv       = 1'b0;

      // two-flop synchronisers
      st_d.scl_meta = pin_in.scl_in;
      st_d.scl_s    = st_q.scl_meta;
      st_d.sda_meta = pin_in.sda_in;
      st_d.sda_s    = st_q.sda_meta;

      // quarter-bit timebase; a released scl held low by the slave stalls it
      if (st_q.state != S_IDLE)
      begin
         if (st_q.div_cnt == DIV_LAST)
         begin
            st_d.div_cnt = '0;
            adv = !(!st_q.pins.scl_oe && !st_q.scl_s);
         end
         else
         begin
            st_d.div_cnt = st_q.div_cnt + 1'b1;
         end
      end

      case (st_q.state)
         S_IDLE:
         begin
            st_d.div_cnt = '0;
            st_d.step    = 2'h0;
            st_d.bit_cnt = 4'h0;
            if (st_q.ctrl[START_BIT])
            begin
               st_d.state       = S_START;
               st_d.pins.scl_oe = 1'b0;
               st_d.pins.sda_oe = 1'b0;
            end
            else if (st_q.ctrl[RSTART_BIT])
            begin
               st_d.state       = S_RSTART;
               st_d.pins.sda_oe = 1'b0;
            end
            else if (st_q.ctrl[STOP_BIT])
            begin
               st_d.state       = S_STOP;
               st_d.pins.sda_oe = 1'b1;
            end
            else if (st_q.ctrl[RECV_BIT] && rx_ready)
            begin
               st_d.state       = S_BITS;
               st_d.mode        = M_RX;
               st_d.pins.sda_oe = 1'b0;
            end
            else if (st_q.ctrl[ACKSEQ_BIT])
            begin
               st_d.state       = S_BITS;
               st_d.mode        = M_ACK;
               st_d.pins.sda_oe = !st_q.ctrl[ACKVAL_BIT];
            end
            else if (st_q.tx_pending)
            begin
               st_d.state       = S_BITS;
               st_d.mode        = M_TX;
               st_d.pins.sda_oe = !st_q.shift[7];
            end
         end
         S_START:
         begin
            if (adv)
            begin
               if (st_q.step == 2'h0)
               begin
                  st_d.pins.sda_oe = 1'b1;
                  st_d.step        = 2'h1;
               end
               else
               begin
                  st_d.pins.scl_oe = 1'b1;
                  clr[START_BIT]   = 1'b1;
                  st_d.state       = S_IDLE;
               end
            end
         end
         S_RSTART:
         begin
            if (adv)
            begin
               case (st_q.step)
                  2'h0:
                  begin
                     st_d.pins.scl_oe = 1'b0;
                     st_d.step        = 2'h1;
                  end
                  2'h1:
                  begin
                     st_d.pins.sda_oe = 1'b1;
                     st_d.step        = 2'h2;
                  end
                  default:
                  begin
                     st_d.pins.scl_oe = 1'b1;
                     clr[RSTART_BIT]  = 1'b1;
                     st_d.state       = S_IDLE;
                  end
               endcase
            end
         end
         S_STOP:
         begin
            if (adv)
            begin
               if (st_q.step == 2'h0)
               begin
                  st_d.pins.scl_oe = 1'b0;
                  st_d.step        = 2'h1;
               end
               else
               begin
                  st_d.pins.sda_oe = 1'b0;
                  clr[STOP_BIT]    = 1'b1;
                  st_d.state       = S_IDLE;
               end
            end
         end
         S_BITS:
         begin
            if (adv)
            begin
               st_d.step = st_q.step + 2'h1;
               case (st_q.step)
                  2'h0:
                  begin
                     st_d.pins.scl_oe = 1'b0;
                  end
                  2'h1:
                  begin
                     if (st_q.mode == M_TX && st_q.bit_cnt == LAST_TX_BIT)
                     begin
                        st_d.ctrl[ACK_RECEIVED_STATUS_BIT] = st_q.sda_s;
                     end
                     else if (st_q.mode == M_RX)
                     begin
                        st_d.shift = {st_q.shift[6:0], st_q.sda_s};
                     end
                  end
                  2'h2:
                  begin
                     st_d.pins.scl_oe = 1'b1;
                  end
                  default:
                  begin
                     if (st_q.mode == M_ACK)
                     begin
                        st_d.pins.sda_oe = 1'b0;
                        clr[ACKSEQ_BIT]  = 1'b1;
                        st_d.state       = S_IDLE;
                     end
                     else if (st_q.mode == M_RX && st_q.bit_cnt == LAST_RX_BIT)
                     begin
                        st_d.push      = 1'b1;
                        clr[RECV_BIT]  = 1'b1;
                        st_d.state     = S_IDLE;
                     end
                     else if (st_q.mode == M_TX && st_q.bit_cnt == LAST_TX_BIT)
                     begin
                        st_d.tx_pending = 1'b0;
                        st_d.state      = S_IDLE;
                     end
                     else
                     begin
                        st_d.bit_cnt = st_q.bit_cnt + 4'h1;
                        if (st_q.mode == M_TX)
                        begin
                           st_d.shift       = {st_q.shift[6:0], 1'b0};
                           // ninth bit: release data for the slave's ack
                           st_d.pins.sda_oe = (st_q.bit_cnt == LAST_RX_BIT) ? 1'b0
                                                                             : !st_q.shift[6];
                        end
                     end
                  end
               endcase
            end
         end
         default:
         begin
            st_d.state = S_IDLE;
         end
      endcase

      // hardware clears; a software set in the same cycle wins
      st_d.ctrl = st_d.ctrl & ~clr;

      // avalon slave: one wait state, effects at the edge with waitrequest low
      if ((avs_read || avs_write) && st_q.wait_q)
      begin
         st_d.wait_q = 1'b0;
         case (avs_address)
            CTRL_OFS:   st_d.rdata = {24'h000000, 1'b0, st_q.ctrl[6:0]};
            RXDATA_OFS: st_d.rdata = {24'h000000, rx_byte};
            STATUS_OFS: st_d.rdata = {28'h0000000, !rx_ready, st_q.state != S_IDLE,
                                      rx_valid, st_q.tx_pending};
            default:    st_d.rdata = 32'h00000000;
         endcase
      end
      else
      begin
         st_d.wait_q = 1'b1;
      end

      if (fire && avs_write)
      begin
         if (avs_address == CTRL_OFS)
         begin
            st_d.ctrl = st_d.ctrl | (avs_writedata[7:0] & REQ_MASK);
            st_d.ctrl[ACKVAL_BIT] = avs_writedata[ACKVAL_BIT];
         end
         else if (avs_address == TXDATA_OFS && !st_q.tx_pending && st_q.state == S_IDLE)
         begin
            st_d.shift      = avs_writedata[7:0];
            st_d.tx_pending = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q <= ST_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign avs_readdata    = st_q.rdata;
   assign avs_waitrequest = st_q.wait_q;
   assign pin_out         = st_q.pins;

   // checks
   property p_ack_drive;
      @(posedge clock) disable iff (!rst_b)
      (st_q.state == S_BITS && st_q.mode == M_ACK && st_q.step != 2'h0)
         |-> (st_q.pins.sda_oe == !st_q.ctrl[ACKVAL_BIT]);
   endproperty
   a_ack_drive : assert property (p_ack_drive) else $error("ack bit drive wrong");

   property p_ack_clear;
      @(posedge clock) disable iff (!rst_b)
      $fell(st_q.ctrl[ACKSEQ_BIT])
         |-> $past(st_q.state == S_BITS && st_q.mode == M_ACK && st_q.step == 2'h3);
   endproperty
   a_ack_clear : assert property (p_ack_clear) else $error("ack request cleared early");

   property p_rx_release;
      @(posedge clock) disable iff (!rst_b)
      (st_q.state == S_BITS && st_q.mode == M_RX) |-> !st_q.pins.sda_oe;
   endproperty
   a_rx_release : assert property (p_rx_release) else $error("data driven in receive");

   property p_rx_push;
      @(posedge clock) disable iff (!rst_b)
      $fell(st_q.ctrl[RECV_BIT]) |-> st_q.push ##1 !st_q.push;
   endproperty
   a_rx_push : assert property (p_rx_push) else $error("receive ended without byte");

   property p_stop_done;
      @(posedge clock) disable iff (!rst_b)
      $fell(st_q.ctrl[STOP_BIT])
         |-> (!st_q.pins.sda_oe && !st_q.pins.scl_oe && st_q.state == S_IDLE);
   endproperty
   a_stop_done : assert property (p_stop_done) else $error("stop left lines driven");

   property p_rstart_done;
      @(posedge clock) disable iff (!rst_b)
      $fell(st_q.ctrl[RSTART_BIT])
         |-> (st_q.pins.sda_oe && st_q.pins.scl_oe && $past(st_q.state == S_RSTART));
   endproperty
   a_rstart_done : assert property (p_rstart_done) else $error("restart ended wrong");

   property p_start_done;
      @(posedge clock) disable iff (!rst_b)
      $fell(st_q.ctrl[START_BIT])
         |-> (st_q.pins.sda_oe && st_q.pins.scl_oe && $past(st_q.state == S_START));
   endproperty
   a_start_done : assert property (p_start_done) else $error("start ended wrong");

   property p_ack_status;
      @(posedge clock) disable iff (!rst_b)
      (adv && st_q.state == S_BITS && st_q.mode == M_TX && st_q.step == 2'h1
       && st_q.bit_cnt == LAST_TX_BIT)
         |=> (st_q.ctrl[ACK_RECEIVED_STATUS_BIT] == $past(st_q.sda_s));
   endproperty
   a_ack_status : assert property (p_ack_status) else $error("ack status not captured");

   property p_bus_answer;
      @(posedge clock) disable iff (!rst_b)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer : assert property (p_bus_answer) else $error("bus answer not in one cycle");

endmodule : i2c_master_sequencer

/* test/i2c_slave_model.sv */
// behavioural i2c slave for the sequencer bench
// assumes resolved open-drain line levels; released lines read high
`timescale 1ns/1ps
module i2c_slave_model
(
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       rd_mode,
   input  wire logic       ack_en,
   input  wire logic       stretch,
   input  wire logic [7:0] rd_byte,
   output      logic       sda_low,
   output      logic       scl_low,
   output      logic [7:0] got_byte,
   output      logic       ack_seen,
   output      int         start_cnt,
   output      int         stop_cnt
);
   int cnt;
   initial
   begin
      sda_low = 1'b0; scl_low = 1'b0; got_byte = 8'h00; ack_seen = 1'b0;
      start_cnt = 0; stop_cnt = 0; cnt = -1;
   end
   always @(negedge sda)
   begin
      if (scl === 1'b1)
      begin
         start_cnt++;
         cnt = -1;
         sda_low = 1'b0;
      end
   end
   always @(posedge sda)
   begin
      // no stop before the first start: ignores the power-up rise of the lines
      if (scl === 1'b1 && start_cnt > 0)
         stop_cnt++;
   end
   // bits 0..7 are data, slot 8 the acknowledge
   always @(posedge scl)
   begin
      if (cnt < 8)
         got_byte = {got_byte[6:0], sda};
      else
         ack_seen = sda;
   end
   // next bit set while the clock is low; optional clock stretch
   always @(negedge scl)
   begin
      cnt = (cnt == 8) ? 0 : cnt + 1;
      sda_low = rd_mode ? (cnt < 8 && !rd_byte[7 - cnt]) : (cnt == 8 && ack_en);
      if (stretch)
      begin
         scl_low = 1'b1;
         #100 scl_low = 1'b0;
      end
   end
endmodule : i2c_slave_model

/* test/test_i2c_master_sequencer.sv */
// self-checking bench for the i2c master sequencer
// assumes pull-ups on both lines and the slave model on the far side
`timescale 1ns/1ps
module test_i2c_master_sequencer;
   import i2c_master_pkg::*;
   localparam int unsigned DIV_SIM = 4;
   logic              clock;
   logic              rst_b;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [31:0]       avs_writedata;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   pin_sense_t        pin_in;
   pin_drive_t        pin_out;
   logic              rd_mode, ack_en, stretch, sda_low, scl_low, ack_seen;
   logic [7:0]        rd_byte, got_byte;
   logic              scl_line, sda_line;
   int                start_cnt, stop_cnt, error_cnt, n_compared, cyc;
   logic [31:0]       d;

   // pull-ups: a line is low only while someone really pulls it
   assign scl_line = (pin_out.scl_oe !== 1'b1) && (scl_low !== 1'b1);
   assign sda_line = (pin_out.sda_oe !== 1'b1) && (sda_low !== 1'b1);
   assign pin_in   = {scl_line, sda_line};

   i2c_master_sequencer #(.DIV(DIV_SIM)) dut_u
   (
      .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out)
   );
   i2c_slave_model slave_u
   (
      .scl(scl_line), .sda(sda_line), .rd_mode(rd_mode), .ack_en(ack_en),
      .stretch(stretch), .rd_byte(rd_byte), .sda_low(sda_low), .scl_low(scl_low),
      .got_byte(got_byte), .ack_seen(ack_seen), .start_cnt(start_cnt), .stop_cnt(stop_cnt)
   );

   always #4 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;

   task end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task bus_write(input logic [3:0] a, input logic [31:0] wd);
      @(posedge clock);
      avs_address <= a; avs_writedata <= wd; avs_write <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : bus_write

   task bus_read(input logic [3:0] a, output logic [31:0] rd);
      @(posedge clock);
      avs_address <= a; avs_read <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_read

   // next request only after the previous one has cleared
   task wait_clear(input logic [3:0] a, input logic [7:0] mask);
      do bus_read(a, d); while ((d[7:0] & mask) != 8'h00);
   endtask : wait_clear

   task t_regs();
      chk({28'h0, pin_out}, 32'h0);
      bus_read(CTRL_OFS, d);
      chk(d, 32'h0);
      bus_read(STATUS_OFS, d);
      chk(d, 32'h0);
      bus_read(4'h2, d);
      chk(d, 32'h0);
      bus_write(CTRL_OFS, 32'h60);
      bus_read(CTRL_OFS, d);
      chk(d, 32'h20);
      bus_write(CTRL_OFS, 32'h0);
      bus_read(CTRL_OFS, d);
      chk(d, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task t_start();
      int t0;
      t0 = cyc;
      bus_write(CTRL_OFS, 32'h01);
      wait_clear(CTRL_OFS, 8'h01);
      chk(32'(cyc - t0 >= 2 * DIV_SIM), 32'h1);
      chk(start_cnt, 1);
      chk({28'h0, pin_out}, 32'h5);
      $display("test start done");
   endtask : t_start

   task t_tx(input logic [7:0] b, input logic ack);
      ack_en = ack;
      bus_write(TXDATA_OFS, {24'h0, b});
      wait_clear(STATUS_OFS, 8'h01);
      chk(got_byte, b);
      bus_read(CTRL_OFS, d);
      chk(d[ACK_RECEIVED_STATUS_BIT], !ack);
      $display("test transmit done");
   endtask : t_tx

   task t_restart();
      rd_mode = 1'b1; rd_byte = 8'h10;
      bus_write(CTRL_OFS, 32'h02);
      wait_clear(CTRL_OFS, 8'h02);
      chk(start_cnt, 2);
      $display("test restart done");
   endtask : t_restart

   task t_fill();
      stretch = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         bus_write(CTRL_OFS, 32'h08);
         wait_clear(CTRL_OFS, 8'h08);
         rd_byte = 8'h11 + i[7:0];
         bus_write(CTRL_OFS, 32'h10 | (i[0] << ACKVAL_BIT));
         wait_clear(CTRL_OFS, 8'h10);
         chk(ack_seen, i[0]);
      end
      bus_read(STATUS_OFS, d);
      chk(d, 32'h0A);
      bus_write(CTRL_OFS, 32'h08);
      repeat (40 * DIV_SIM) @(posedge clock);
      bus_read(CTRL_OFS, d);
      chk(d[RECV_BIT], 1'b1);
      $display("test fill done");
   endtask : t_fill

   task t_drain();
      bus_read(RXDATA_OFS, d);
      chk(d[7:0], 8'h10);
      wait_clear(CTRL_OFS, 8'h08);
      // slave leaves data released after the last ack so the stop can rise
      rd_byte = 8'hFF;
      bus_write(CTRL_OFS, 32'h30);
      wait_clear(CTRL_OFS, 8'h10);
      chk(ack_seen, 1'b1);
      for (int i = 1; i <= 8; i++)
      begin
         bus_read(RXDATA_OFS, d);
         chk(d[7:0], 8'h10 + i[7:0]);
      end
      bus_read(STATUS_OFS, d);
      chk(d, 32'h0);
      $display("test drain done");
   endtask : t_drain

   task t_stop();
      bus_write(CTRL_OFS, 32'h04);
      wait_clear(CTRL_OFS, 8'h04);
      chk(stop_cnt, 1);
      chk({28'h0, pin_out}, 32'h0);
      $display("test stop done");
   endtask : t_stop

   initial
   begin
      clock = 1'b0; rst_b = 1'b0; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
      avs_writedata = 32'h0; rd_mode = 1'b0; ack_en = 1'b1; stretch = 1'b0;
      rd_byte = 8'h00; error_cnt = 0; n_compared = 0; cyc = 0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      t_regs();
      t_start();
      t_tx(8'hA5, 1'b1);
      t_tx(8'h3C, 1'b0);
      t_restart();
      t_fill();
      t_drain();
      t_stop();
      end_of_test();
   end

   initial
   begin
      repeat (30000) @(posedge clock);
      error_cnt++;
      end_of_test();
   end
endmodule : test_i2c_master_sequencer
